// File: design/tpw_pkg.sv
// Package: constants, types and timing for the two-channel timer/PWM unit
package tpw_pkg;

  // ------------------------------------------------------------
  // Widths and encodings
  // ------------------------------------------------------------
  localparam int unsigned CNT_W     = 16;
  localparam int unsigned NUM_CH    = 2;
  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam logic [15:0] MOD_FREE0 = 16'h0000;
  localparam logic [15:0] MOD_FREE1 = 16'hffff;

  // Clock source codes
  localparam logic [1:0] CLK_OFF    = 2'h0;
  localparam logic [1:0] CLK_BUS    = 2'h1;
  localparam logic [1:0] CLK_UNUSED = 2'h2;
  localparam logic [1:0] CLK_XTAL   = 2'h3;

  // Channel mode codes (mode field of each channel)
  localparam logic [1:0] MODE_CAPT  = 2'h0;
  localparam logic [1:0] MODE_CMP   = 2'h1;
  localparam logic [1:0] MODE_EPWM  = 2'h2;

  // Edge / action codes share one 2-bit field
  localparam logic [1:0] EDGE_RISE  = 2'h1;
  localparam logic [1:0] EDGE_FALL  = 2'h2;
  localparam logic [1:0] EDGE_ANY   = 2'h3;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_CLEAR  = 2'h2;
  localparam logic [1:0] ACT_SET    = 2'h3;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int unsigned CLK_HZ      = 20000000;
  localparam int unsigned XTAL_CLK_HZ = 500000;
  localparam int unsigned XTAL_CYC    = CLK_HZ / XTAL_CLK_HZ;  // period in clk_i cycles
  localparam logic [2:0]  PS_RESET    = 3'h0;

  // ------------------------------------------------------------
  // Carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic [1:0]  mode;     // capture / compare / edge pwm
    logic [1:0]  edge_act; // capture edge or compare action
    logic        pol_low;  // pwm low-true
    logic        ie;       // channel interrupt enable
    logic [15:0] value;    // compare / duty value
  } tpw_ch_cfg_t;

  typedef struct packed {
    logic [1:0] clk_sel;     // clk_select_hi, clk_select_lo
    logic [2:0] prescale;    // divide by 2**prescale
    logic       center_aligned_pwm;
    logic       ovf_ie;      // overflow interrupt enable
  } tpw_ctrl_t;

endpackage : tpw_pkg

// File: design/tpw_channel.sv
// Single timer channel: capture, compare, edge and center PWM
module tpw_channel
  import tpw_pkg::*;
(
  input  wire logic        clk_i,      // Bus clock
  input  wire logic        resetn_i,   // Async reset, active low
  input  wire tpw_ch_cfg_t cfg_i,      // Channel configuration
  input  wire logic        center_aligned_pwm_i,     // Center-aligned mode
  input  wire logic        tick_i,     // Counter advances this cycle
  input  wire logic        wrap_i,     // Counter period restarts
  input  wire logic [15:0] count_i,    // Current counter value
  input  wire logic        pin_i,      // Sampled channel input
  input  wire logic        flag_clr_i, // Software clears channel flag
  output logic             out_o,      // Channel output level
  output logic [15:0]      capt_o,     // Captured counter value
  output logic             flag_o,     // Channel event flag
  output logic             irq_o       // Channel interrupt
);

  logic        pin_d;
  logic        rise;
  logic        fall;
  logic        capt_hit;
  logic        match;
  logic [15:0] duty;

  // ------------------------------------------------------------
  // Edge detect and duty buffer
  // ------------------------------------------------------------
  assign rise     = pin_i & ~pin_d;
  assign fall     = ~pin_i & pin_d;
  assign capt_hit = (cfg_i.edge_act[0] & rise) | (cfg_i.edge_act[1] & fall);
  assign match    = tick_i && (count_i == cfg_i.value);

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pin_d <= 1'b0;
    end else begin
      pin_d <= pin_i;
    end
  end

  // Duty reloads only at period start so a pulse never glitches
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      duty <= CNT_RESET;
    end else if (wrap_i) begin
      duty <= cfg_i.value;
    end
  end

  // ------------------------------------------------------------
  // Capture register
  // ------------------------------------------------------------
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      capt_o <= CNT_RESET;
    end else if (!center_aligned_pwm_i && cfg_i.mode == MODE_CAPT && capt_hit) begin
      capt_o <= count_i;
    end
  end

  // ------------------------------------------------------------
  // Output level
  // ------------------------------------------------------------
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      out_o <= 1'b0;
    end else if (center_aligned_pwm_i || cfg_i.mode == MODE_EPWM) begin
      // Active while count below duty, polarity applied last
      out_o <= (count_i < duty) ^ cfg_i.pol_low;
    end else if (cfg_i.mode == MODE_CMP && match) begin
      case (cfg_i.edge_act)
        ACT_TOGGLE: out_o <= ~out_o;
        ACT_CLEAR:  out_o <= 1'b0;
        ACT_SET:    out_o <= 1'b1;
        default:    out_o <= out_o;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Event flag and interrupt; a new event beats the clear
  // ------------------------------------------------------------
  logic event_hit;
  assign event_hit = (center_aligned_pwm_i || cfg_i.mode != MODE_CAPT) ? match : capt_hit;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      flag_o <= 1'b0;
      irq_o  <= 1'b0;
    end else begin
      flag_o <= event_hit | (flag_o & ~flag_clr_i);
      irq_o  <= cfg_i.ie & (event_hit | (flag_o & ~flag_clr_i));
    end
  end

endmodule : tpw_channel

// File: design/tpw_timer.sv
// Top: two-channel timer/PWM unit with 16-bit counter and prescaler
// Notes on behaviour
// - Two channels, each capture, compare or PWM
// - Buffered center-aligned PWM on all channels
// - Clock select: off, bus, unused, crystal
// - Prescale divide 1 to 128 in powers
// - 16-bit counter, up or up/down
// - Modulo value sets counter upper limit
// - Interrupt per channel plus terminal count
// - Capture on rising, falling or any edge
// - Compare sets, clears or toggles output
// - PWM polarity high-true or low-true
// - External source is 500 kHz crystal clock
// - Route pin or slow oscillator to channel zero
// - Pins shared; unused pins keep other functions
// - Overflow flag: read-then-write-zero clear, overflow wins
// - Counter write resets; reading never disturbs
// - Modulo 0000 or ffff means free running
module tpw_timer
  import tpw_pkg::*;
(
  input  wire logic        clk_i,            // 20 MHz bus clock
  input  wire logic        resetn_i,         // Async reset, active low
  input  wire tpw_ctrl_t   ctrl_i,           // Global control fields
  input  wire logic [15:0] modulo_i,         // Counter modulo value
  input  wire tpw_ch_cfg_t ch0_cfg_i,        // Channel 0 configuration
  input  wire tpw_ch_cfg_t ch1_cfg_i,        // Channel 1 configuration
  input  wire logic        ch0_en_i,         // Channel 0 owns its pin
  input  wire logic        ch1_en_i,         // Channel 1 owns its pin
  input  wire logic        crystal_derived_clock_i, // 500 kHz crystal clock level
  input  wire logic        slow_oscillator_i,       // Slow oscillator level
  input  wire logic        slow_osc_route_sel_i,    // 1: slow osc to channel 0
  input  wire logic [1:0]  port_a_pins_hi_i,        // Pin levels in
  input  wire logic        count_wr_i,       // Write strobe to either counter byte
  input  wire logic        status_rd_i,      // Status register read strobe
  input  wire logic        ovf_wr0_i,        // Write of 0 to overflow flag
  input  wire logic [1:0]  ch_flag_clr_i,    // Channel flag clear strobes
  output logic [15:0]      count_value_o,    // Counter value
  output logic             overflow_flag_o,  // Overflow flag
  output logic             ovf_irq_o,        // Terminal count interrupt
  output logic [1:0]       ch_irq_o,         // Channel interrupts
  output logic [1:0]       ch_flag_o,        // Channel flags
  output logic [15:0]      ch0_capt_o,       // Channel 0 captured value
  output logic [15:0]      ch1_capt_o,       // Channel 1 captured value
  output logic [1:0]       port_a_pins_hi_o, // Pin drive levels
  output logic [1:0]       port_a_pins_hi_oe_n_o // Low while timer drives pin
);

  // ------------------------------------------------------------
  // Source select and prescaler
  // ------------------------------------------------------------
  logic        xtal_d;
  logic        src_tick;
  logic [6:0]  pre_cnt;
  logic        tick;
  logic        dir_down;
  logic        wrap;
  logic        free_run;
  logic [15:0] top;
  logic        arm;
  logic        ovf_set;
  logic [1:0]  ch_in;
  logic [1:0]  ch_out;

  // Prescale tap mask: divide by 2**ps
  function automatic logic [6:0] ps_mask(input logic [2:0] ps);
    ps_mask = 7'((8'h01 << ps) - 8'h01);
  endfunction : ps_mask

  // Crystal clock taken as level; rising edge is one tick
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      xtal_d <= 1'b0;
    end else begin
      xtal_d <= crystal_derived_clock_i;
    end
  end

  always_comb begin
    case (ctrl_i.clk_sel)
      CLK_BUS:  src_tick = 1'b1;
      CLK_XTAL: src_tick = crystal_derived_clock_i & ~xtal_d;
      default:  src_tick = 1'b0;                                // Off or unused
    endcase
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pre_cnt <= 7'h00;
    end else if (ctrl_i.clk_sel == CLK_OFF || count_wr_i) begin
      pre_cnt <= 7'h00;
    end else if (src_tick) begin
      pre_cnt <= ((pre_cnt & ps_mask(ctrl_i.prescale)) == ps_mask(ctrl_i.prescale))
                 ? 7'h00 : 7'(pre_cnt + 7'h01);
    end
  end

  assign tick = src_tick && ((pre_cnt & ps_mask(ctrl_i.prescale)) == ps_mask(ctrl_i.prescale));

  // ------------------------------------------------------------
  // Counter
  // ------------------------------------------------------------
  assign free_run = (modulo_i == MOD_FREE0) || (modulo_i == MOD_FREE1);
  assign top      = free_run ? MOD_FREE1 : modulo_i;
  // Up mode: wrap at top; center mode: turn at top marks overflow
  assign wrap     = tick && (ctrl_i.center_aligned_pwm
                    ? (!dir_down && count_value_o == top)
                    : (count_value_o == top));
  assign ovf_set  = wrap;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      count_value_o <= CNT_RESET;
      dir_down      <= 1'b0;
    end else if (count_wr_i) begin
      count_value_o <= CNT_RESET;  // Any data value resets
      dir_down      <= 1'b0;
    end else if (tick) begin
      if (!ctrl_i.center_aligned_pwm) begin
        dir_down      <= 1'b0;
        count_value_o <= wrap ? CNT_RESET : 16'(count_value_o + 16'h0001);
      end else if (!dir_down) begin
        if (count_value_o >= top) begin
          dir_down      <= 1'b1;
          count_value_o <= 16'(count_value_o - 16'h0001);
        end else begin
          count_value_o <= 16'(count_value_o + 16'h0001);
        end
      end else begin
        if (count_value_o == CNT_RESET || count_value_o == 16'h0001) begin
          dir_down <= 1'b0;
        end
        count_value_o <= (count_value_o == CNT_RESET) ? 16'h0001
                         : 16'(count_value_o - 16'h0001);
      end
    end
  end

  // ------------------------------------------------------------
  // Overflow flag: read arms, write of 0 clears, new overflow disarms
  // ------------------------------------------------------------
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      overflow_flag_o <= 1'b0;
      arm             <= 1'b0;
      ovf_irq_o       <= 1'b0;
    end else begin
      if (ovf_set) begin
        overflow_flag_o <= 1'b1;   // Set beats clear
        arm             <= 1'b0;
      end else if (ovf_wr0_i && arm) begin
        overflow_flag_o <= 1'b0;
        arm             <= 1'b0;
      end else if (status_rd_i && overflow_flag_o) begin
        arm <= 1'b1;
      end
      ovf_irq_o <= ctrl_i.ovf_ie & (ovf_set | (overflow_flag_o & ~(ovf_wr0_i & arm)));
    end
  end

  // ------------------------------------------------------------
  // Channels and pin sharing
  // ------------------------------------------------------------
  assign ch_in[0] = slow_osc_route_sel_i ? slow_oscillator_i : port_a_pins_hi_i[0];
  assign ch_in[1] = port_a_pins_hi_i[1];

  tpw_channel u_ch0 (
    .clk_i      (clk_i),
    .resetn_i   (resetn_i),
    .cfg_i      (ch0_cfg_i),
    .center_aligned_pwm_i     (ctrl_i.center_aligned_pwm),
    .tick_i     (tick),
    .wrap_i     (wrap),
    .count_i    (count_value_o),
    .pin_i      (ch_in[0]),
    .flag_clr_i (ch_flag_clr_i[0]),
    .out_o      (ch_out[0]),
    .capt_o     (ch0_capt_o),
    .flag_o     (ch_flag_o[0]),
    .irq_o      (ch_irq_o[0])
  );

  tpw_channel u_ch1 (
    .clk_i      (clk_i),
    .resetn_i   (resetn_i),
    .cfg_i      (ch1_cfg_i),
    .center_aligned_pwm_i     (ctrl_i.center_aligned_pwm),
    .tick_i     (tick),
    .wrap_i     (wrap),
    .count_i    (count_value_o),
    .pin_i      (ch_in[1]),
    .flag_clr_i (ch_flag_clr_i[1]),
    .out_o      (ch_out[1]),
    .capt_o     (ch1_capt_o),
    .flag_o     (ch_flag_o[1]),
    .irq_o      (ch_irq_o[1])
  );

  // Drive a pin only when the channel owns it and is an output
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      port_a_pins_hi_o      <= 2'h0;
      port_a_pins_hi_oe_n_o <= 2'h3;
    end else begin
      port_a_pins_hi_o         <= ch_out;
      port_a_pins_hi_oe_n_o[0] <= ~(ch0_en_i && ctrl_i.clk_sel != CLK_OFF &&
                                  (ctrl_i.center_aligned_pwm || ch0_cfg_i.mode != MODE_CAPT));
      port_a_pins_hi_oe_n_o[1] <= ~(ch1_en_i && ctrl_i.clk_sel != CLK_OFF &&
                                  (ctrl_i.center_aligned_pwm || ch1_cfg_i.mode != MODE_CAPT));
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  sequence s_read_armed;
    status_rd_i && overflow_flag_o && !ovf_set;
  endsequence

  sequence s_zero_write;
    ovf_wr0_i && !ovf_set;
  endsequence

  a_ovf_clear_seq: assert property (@(posedge clk_i) disable iff (!resetn_i)
    s_read_armed ##1 (s_zero_write and !status_rd_i) |=> !overflow_flag_o)
    else $error("overflow flag not cleared by read then zero write");

  a_ovf_set_wins: assert property (@(posedge clk_i) disable iff (!resetn_i)
    ovf_set |=> overflow_flag_o)
    else $error("overflow lost");

  a_cnt_wr_reset: assert property (@(posedge clk_i) disable iff (!resetn_i)
    count_wr_i |=> count_value_o == CNT_RESET)
    else $error("counter write did not reset");

  a_clk_off_hold: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (ctrl_i.clk_sel == CLK_OFF && !count_wr_i) |=> $stable(count_value_o))
    else $error("counter moved while disabled");

  a_bus_div1_step: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (ctrl_i.clk_sel == CLK_BUS && ctrl_i.prescale == PS_RESET && !count_wr_i
     && !ctrl_i.center_aligned_pwm && count_value_o != top)
    |=> count_value_o == 16'($past(count_value_o) + 16'h0001))
    else $error("counter did not step each bus cycle");

  a_wrap_zero: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (wrap && !ctrl_i.center_aligned_pwm && !count_wr_i) |=> count_value_o == CNT_RESET)
    else $error("counter did not wrap to zero");

  // A zero modulo must not pin the counter at zero
  a_free_top: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (modulo_i == MOD_FREE0 && tick && !ctrl_i.center_aligned_pwm && !count_wr_i
     && count_value_o == CNT_RESET) |=> count_value_o == 16'h0001)
    else $error("zero modulo did not run free");

  a_center_aligned_pwm_turn: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (tick && ctrl_i.center_aligned_pwm && !dir_down && count_value_o == top
     && top != CNT_RESET && !count_wr_i) |=> dir_down)
    else $error("center mode did not turn down at top");

  // Edge of the routed oscillator must reach the channel zero capture logic
  a_ch0_route: assert property (@(posedge clk_i) disable iff (!resetn_i)
    ($past(resetn_i) && slow_osc_route_sel_i && $past(slow_osc_route_sel_i)
     && !ctrl_i.center_aligned_pwm && ch0_cfg_i.mode == MODE_CAPT
     && ch0_cfg_i.edge_act == EDGE_ANY
     && slow_oscillator_i != $past(slow_oscillator_i)) |=> ch_flag_o[0])
    else $error("slow oscillator edge not seen on channel zero");

endmodule : tpw_timer

// File: bench/tpw_pin_model.sv
// Far-side model: crystal clock, slow oscillator and the two shared pins
module tpw_pin_model
  import tpw_pkg::*;
#(
  parameter int SLOW_HALF = 64 // Slow oscillator half period in clk_i cycles
) (
  input  wire logic       clk_i,     // Bus clock
  input  wire logic [1:0] ext_drv_i, // Level the outside world drives
  input  wire logic [1:0] out_i,     // Timer drive levels
  input  wire logic [1:0] oe_n_i,    // Timer enables, low while driving
  output logic [1:0]      pin_o,     // Resolved pin levels
  output logic            xtal_o,    // Crystal-derived clock
  output logic            slow_o     // Slow oscillator
);
  timeunit 1ns;
  timeprecision 1ps;

  // ------------------------------------------------------------
  // Oscillators
  // ------------------------------------------------------------
  // Free-running crystal clock, unrelated in phase to clk_i
  initial begin
    xtal_o = 1'b0;
    #7;
    forever #(500000000 / XTAL_CLK_HZ) xtal_o = ~xtal_o;
  end

  // Slow oscillator, shortened so a capture fits a short run
  initial begin
    slow_o = 1'b0;
    forever begin
      repeat (SLOW_HALF) @(posedge clk_i);
      slow_o <= ~slow_o;
    end
  end

  // ------------------------------------------------------------
  // Pins
  // ------------------------------------------------------------
  // Timer wins a pin only while it enables its driver
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      pin_o[i] = oe_n_i[i] ? ext_drv_i[i] : out_i[i];
    end
  end
endmodule : tpw_pin_model

// File: bench/test_tpw_timer.sv
// Testbench for the two-channel timer/PWM unit
module test_tpw_timer
  import tpw_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk_i = 1'b0;
  logic        resetn = 1'b0;
  tpw_ctrl_t   ctrl = '0;
  logic [15:0] modulo = 16'h0000;
  tpw_ch_cfg_t c0 = '0;
  tpw_ch_cfg_t c1 = '0;
  logic        en0 = 1'b0;
  logic        en1 = 1'b0;
  logic        sel = 1'b0;
  logic        cwr = 1'b0;
  logic        srd = 1'b0;
  logic        owr0 = 1'b0;
  logic [1:0]  fclr = 2'h0;
  logic [1:0]  ext = 2'h0;
  logic [1:0]  pin, pout, poe_n, chirq, chflag;
  logic [15:0] cnt, capt0, capt1, p;
  logic        ovf, ovf_irq, xtal, slow, wr, up, f;
  logic [1:0]  acts [3] = '{ACT_TOGGLE, ACT_CLEAR, ACT_SET};
  int          fail_count = 0;
  int          n_tests = 0;
  int          i, e, h, k;

  tpw_timer DUT (
    .clk_i(clk_i), .resetn_i(resetn), .ctrl_i(ctrl), .modulo_i(modulo),
    .ch0_cfg_i(c0), .ch1_cfg_i(c1), .ch0_en_i(en0), .ch1_en_i(en1),
    .crystal_derived_clock_i(xtal), .slow_oscillator_i(slow),
    .slow_osc_route_sel_i(sel), .port_a_pins_hi_i(pin), .count_wr_i(cwr),
    .status_rd_i(srd), .ovf_wr0_i(owr0), .ch_flag_clr_i(fclr),
    .count_value_o(cnt), .overflow_flag_o(ovf), .ovf_irq_o(ovf_irq),
    .ch_irq_o(chirq), .ch_flag_o(chflag), .ch0_capt_o(capt0), .ch1_capt_o(capt1),
    .port_a_pins_hi_o(pout), .port_a_pins_hi_oe_n_o(poe_n));

  tpw_pin_model #(.SLOW_HALF(64)) far_side (
    .clk_i(clk_i), .ext_drv_i(ext), .out_i(pout), .oe_n_i(poe_n),
    .pin_o(pin), .xtal_o(xtal), .slow_o(slow));

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  initial forever #25 clk_i = ~clk_i;

  task automatic check(string nm, logic [15:0] seen, logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : print_verdict

  task automatic cyc(int n);
    repeat (n) @(posedge clk_i);
    @(negedge clk_i);
  endtask : cyc

  // Counter write realigns counter, prescaler and direction
  task automatic setup(logic [1:0] cs, logic [2:0] ps, logic cp, logic [15:0] md);
    @(posedge clk_i);
    ctrl <= '{cs, ps, cp, 1'b1};
    modulo <= md;
    @(posedge clk_i) cwr <= 1'b1;
    @(posedge clk_i) cwr <= 1'b0;
    @(negedge clk_i);
  endtask : setup

  // 0 status read, 1 write zero to flag, 2/3 channel flag clears
  task automatic strobe(int n);
    @(posedge clk_i);
    {fclr, owr0, srd} <= 4'h1 << n;
    @(posedge clk_i);
    {fclr, owr0, srd} <= 4'h0;
    @(negedge clk_i);
  endtask : strobe

  // Window length a multiple of every tick period, so the count is exact
  task automatic delta(int n, logic [15:0] exp);
    logic [15:0] a;
    a = cnt;
    repeat (n) @(negedge clk_i);
    check("count advance", cnt - a, exp);
  endtask : delta

  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
    check("count reset", cnt, 16'h0000);
    check("pin enables reset", poe_n, 2'h3);
    @(posedge clk_i) resetn <= 1'b1;
    setup(CLK_BUS, 3'h0, 1'b0, 16'h0003);
    wr = 1'b0;
    p = cnt;
    for (i = 0; i < 12; i++) begin
      @(negedge clk_i);
      wr |= (p == 16'h0003);
      check("modulo count", cnt, (p == 16'h0003) ? 16'h0000 : p + 16'h0001);
      check("overflow set", ovf, wr);
      p = cnt;
    end
    check("overflow irq", ovf_irq, 1'b1);
    $display("test wrap done");
    // Free run: no further overflow may sneak in
    setup(CLK_BUS, 3'h0, 1'b0, 16'h0000);
    strobe(1);
    cyc(1);
    check("clear needs read", ovf, 1'b1);
    strobe(0);
    strobe(1);
    cyc(1);
    check("overflow cleared", ovf, 1'b0);
    check("overflow irq off", ovf_irq, 1'b0);
    delta(40, 16'h0028);
    setup(CLK_BUS, 3'h0, 1'b0, 16'h0003);
    // Read lands between wraps, a wrap follows, the zero write misses both
    cyc(5);
    strobe(0);
    cyc(5);
    strobe(1);
    cyc(1);
    check("overflow wins", ovf, 1'b1);
    // Read and zero write on adjacent edges, far from any wrap
    setup(CLK_BUS, 3'h0, 1'b0, 16'h0000);
    @(posedge clk_i) srd <= 1'b1;
    @(posedge clk_i) {owr0, srd} <= 2'b10;
    @(posedge clk_i) owr0 <= 1'b0;
    cyc(1);
    check("adjacent clear", ovf, 1'b0);
    $display("test overflow clear done");
    for (i = 0; i < 8; i++) begin
      setup(CLK_BUS, i[2:0], 1'b0, 16'hffff);
      delta(256, 16'(256 >> i));
    end
    setup(CLK_OFF, 3'h0, 1'b0, 16'h0000);
    delta(64, 16'h0000);
    setup(CLK_UNUSED, 3'h0, 1'b0, 16'h0000);
    delta(64, 16'h0000);
    setup(CLK_XTAL, 3'h0, 1'b0, 16'h0000);
    delta(400, 16'h000a);
    $display("test clock source done");
    @(posedge clk_i);
    en0 <= 1'b1;
    c1 <= '{MODE_CMP, ACT_SET, 1'b0, 1'b0, 16'h0008};
    for (i = 0; i < 3; i++) begin
      @(posedge clk_i) c0 <= '{MODE_CMP, acts[i], 1'b0, 1'b1, 16'h0008};
      setup(CLK_BUS, 3'h0, 1'b0, 16'h0000);
      cyc(16);
      check("compare pin", pin[0], i != 1);
      check("pin ownership", poe_n, 2'h2);
      check("compare flag", chflag[0], 1'b1);
      check("compare irq", chirq[0], 1'b1);
      check("masked irq", chirq[1], 1'b0);
      strobe(2);
      check("flag cleared", chflag[0], 1'b0);
    end
    $display("test compare done");
    for (i = 0; i < 2; i++) begin
      @(posedge clk_i) c0 <= '{MODE_EPWM, 2'h0, i[0], 1'b0, 16'h0004};
      setup(CLK_BUS, 3'h0, 1'b0, 16'h000f);
      cyc(20);
      h = 0;
      repeat (32) begin
        @(negedge clk_i);
        h += pin[0];
      end
      check("pwm high cycles", 16'(h), i ? 16'h0018 : 16'h0008);
    end
    $display("test pwm done");
    @(posedge clk_i) en1 <= 1'b1;
    setup(CLK_BUS, 3'h7, 1'b0, 16'h0000);
    for (e = 1; e < 4; e++) begin
      @(posedge clk_i);
      c1 <= '{MODE_CAPT, e[1:0], 1'b0, 1'b0, 16'h0000};
      c0 <= '{MODE_CAPT, e[1:0], 1'b0, 1'b0, 16'h0000};
      cyc(4);
      strobe(3);
      for (h = 1; h >= 0; h--) begin
        p = cnt;
        k = 0;
        while (cnt === p && k < 300) begin
          @(negedge clk_i);
          k++;
        end
        p = cnt;
        @(posedge clk_i) ext <= {2{h[0]}};
        cyc(6);
        f = h ? e[0] : e[1];
        check("capture flag", chflag[1], f);
        if (f) check("capture value", capt1, p);
        if (f) check("capture value 0", capt0, p);
        strobe(3);
      end
    end
    $display("test capture done");
    @(posedge clk_i) c0 <= '{MODE_CAPT, EDGE_ANY, 1'b0, 1'b0, 16'h0000};
    for (i = 0; i < 2; i++) begin
      @(posedge clk_i) sel <= i[0];
      cyc(4);
      strobe(2);
      cyc(140);
      check("slow osc route", chflag[0], i[0]);
    end
    $display("test route done");
    setup(CLK_BUS, 3'h0, 1'b1, 16'h0004);
    up = 1'b1;
    p = cnt;
    for (i = 0; i < 20; i++) begin
      @(negedge clk_i);
      if (p == 16'h0004) up = 1'b0;
      else if (p == 16'h0000) up = 1'b1;
      check("center count", cnt, up ? p + 16'h0001 : p - 16'h0001);
      p = cnt;
    end
    $display("test center done");
    print_verdict();
  end

  // Tests take about 4000 cycles
  initial begin
    repeat (30000) @(posedge clk_i);
    fail_count++;
    $display("watchdog expired");
    print_verdict();
  end
endmodule : test_tpw_timer
